// ==== hw/keypad_pkg.sv ====
// Shared constants and types for the keypad scanner and event queue
package keypad_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_INT_CONFIG  = 8'h01; // Interrupt config
  localparam logic [7:0] ADDR_INT_STATUS  = 8'h02; // Interrupt status
  localparam logic [7:0] ADDR_LOCK_COUNT  = 8'h03; // Lock and event count
  localparam logic [7:0] ADDR_QUEUE_FIRST = 8'h04; // First event register
  localparam logic [7:0] ADDR_QUEUE_LAST  = 8'h0d; // Last event register
  localparam logic [7:0] ADDR_MATRIX_ROWS = 8'h1d; // Rows in matrix
  localparam logic [7:0] ADDR_MATRIX_COLA = 8'h1e; // Columns 0 to 7
  localparam logic [7:0] ADDR_MATRIX_COLB = 8'h1f; // Columns 8 and 9
  // Field positions in interrupt_config
  localparam int CFG_KEY_IRQ_BIT  = 0; // Key event irq enable
  localparam int CFG_OVR_IEN_BIT  = 1; // Overrun irq enable
  localparam int CFG_OVR_MODE_BIT = 5; // Overwrite on overrun
  // Field positions in interrupt_status
  localparam int STS_KE_BIT  = 0; // Key event flag
  localparam int STS_OVR_BIT = 1; // Overrun flag
  // Reset values
  localparam logic [7:0] CONFIG_RESET = 8'h00; // All irqs off, discard
  localparam logic [7:0] MATRIX_RESET = 8'h00; // No line in matrix
  // Matrix geometry
  localparam int ROWS = 8;  // Row lines
  localparam int COLS = 10; // Column lines
  localparam int KEYS = ROWS * COLS; // Keys in matrix
  localparam int QUEUE_DEPTH = 10; // Pending events held
  // Timing
  localparam int CLK_MHZ          = 50;    // Core clock rate
  localparam int SAMPLE_PERIOD_US = 25000; // Scan sample period
  localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_US * CLK_MHZ;
  localparam int SETTLE_NS        = 160;   // Column settle time
  localparam int SETTLE_CYCLES    = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  // One queued key event
  typedef struct packed {
    logic       pressed; // One for press
    logic [6:0] code;    // Key code 1 to 80
  } key_event_type;
endpackage

// ==== hw/keypad_scan_event_fifo.sv ====
// Keypad matrix scanner with debounce and ten-entry event queue
// Contract
// - Reset: all lines inputs, pull-ups, debounce
// - Per-line matrix membership from config registers
// - Key code is row times ten plus column plus one
// - Idle: matrix columns low, rows pulled high
// - Row low in idle wakes a column scan
// - Qualified press queued with press flag, detection order
// - Logged event sets flag; irq if enabled
// - Sample every 25 ms; two closed samples
// - Release after two open samples, then idle
// - Any event address reads oldest event
// - Count rises per logged event, max ten
// - Bit 7 press flag, low seven code
// - Each event read removes that event
// - Empty queue reads as zero
// - Event at full queue sets overrun flag
// - Non-full queue appends newest event
// - Overrun mode: discard or overwrite oldest
// - Count falls as events are read
// - Key flag write-one clear refused while queued
// - Interrupt active low open drain
`timescale 1ns/1ns

// Parameterised first-in first-out buffer
module event_fifo #(
  parameter int WIDTH = 8,  // Word width
  parameter int DEPTH = 32  // Words held
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1)-1:0]      count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // Pointer width
  localparam int CW = $clog2(DEPTH + 1);              // Count width
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);    // Last slot
  localparam logic [CW-1:0] FULL = CW'(DEPTH);        // Full count

  logic [WIDTH-1:0] mem [DEPTH];   // Storage
  logic [PW-1:0]    wr_ptr;        // Next slot to write
  logic [PW-1:0]    rd_ptr;        // Oldest slot
  logic             do_push;       // Word taken in
  logic             do_pop;        // Word handed out

  // Full refuses a push unless a pop frees a slot in the same cycle
  assign in_ready  = (count != FULL) || out_ready;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  // Pointer advance with wrap
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  // Storage write
  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= bump(wr_ptr);
      end
      if (do_pop)
      begin
        rd_ptr <= bump(rd_ptr);
      end
      if (do_push && !do_pop)
      begin
        count <= count + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// Scanner, debounce, event queue and register file
module keypad_scan_event_fifo #(
  parameter int SAMPLE_CYCLES = keypad_pkg::SAMPLE_CYCLES, // Sample period
  parameter int SETTLE_CYCLES = keypad_pkg::SETTLE_CYCLES  // Column settle
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic [7:0]                reg_addr,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [7:0]                reg_wdata,
  output logic [7:0]                     reg_rdata,
  input  wire logic [keypad_pkg::ROWS-1:0] matrix_row_lines,
  output logic [keypad_pkg::COLS-1:0]    matrix_column_lines,
  output logic [keypad_pkg::COLS-1:0]    matrix_column_oe,
  output logic [keypad_pkg::ROWS-1:0]    row_pullup_en,
  output logic [keypad_pkg::COLS-1:0]    column_pullup_en,
  output logic [keypad_pkg::ROWS-1:0]    row_debounce_en,
  output logic [keypad_pkg::COLS-1:0]    column_debounce_en,
  output logic                           irq_n_out,
  output logic                           irq_n_oe
);
  localparam int ROWS = keypad_pkg::ROWS;
  localparam int COLS = keypad_pkg::COLS;
  localparam int KEYS = keypad_pkg::KEYS;
  localparam int DEPTH = keypad_pkg::QUEUE_DEPTH;
  localparam int TW = $clog2(SAMPLE_CYCLES + 1); // Timer width
  localparam int SW = $clog2(SETTLE_CYCLES + 4); // Settle counter width
  localparam logic [TW-1:0] T_RELOAD = TW'(SAMPLE_CYCLES - 1);
  localparam logic [SW-1:0] S_DONE = SW'(SETTLE_CYCLES + 3);
  localparam logic [6:0] K_LAST = 7'(KEYS - 1);
  localparam logic [3:0] C_LAST = 4'(COLS - 1);

  typedef enum logic [1:0] {st_idle, st_wait, st_drive, st_walk}
    scan_state_type;

  logic [1:0]            rst_sync;        // Reset release chain
  logic                  rst_int_n;       // Synchronised reset
  logic [ROWS-1:0]       row_s1;          // Synchroniser stage 1
  logic [ROWS-1:0]       row_s2;          // Synchroniser stage 2
  logic [ROWS-1:0]       row_s3;          // Synchroniser stage 3
  logic [ROWS-1:0]       row_level;       // Agreed row level
  logic [ROWS-1:0]       row_en;          // Rows in matrix
  logic [COLS-1:0]       col_en;          // Columns in matrix
  logic [7:0]            int_config;      // Interrupt config register
  logic                  key_event_flag;  // Sticky key event
  logic                  queue_overrun_flag; // Sticky overrun
  scan_state_type        state;           // Scanner state
  logic [TW-1:0]         timer;           // Sample period timer
  logic [SW-1:0]         settle;          // Column settle counter
  logic [3:0]            scan_col;        // Column being driven
  logic [6:0]            walk_k;          // Key index being walked
  logic [KEYS-1:0]       cur;             // Current sample, one closed
  logic [KEYS-1:0]       prev;            // Previous sample
  logic [KEYS-1:0]       pressed;         // Debounced key state
  logic                  busy;            // Activity seen during walk
  logic                  press_k;         // Walked key becomes pressed
  logic                  release_k;       // Walked key becomes released
  logic                  ev_valid;        // Event offered to queue
  keypad_pkg::key_event_type ev;          // Event offered
  keypad_pkg::key_event_type head;        // Oldest queued event
  logic                  walk_step;       // Walk may advance
  logic                  fifo_in_ready;   // Queue can take event
  logic                  fifo_out_valid;  // Queue not empty
  logic                  fifo_out_ready;  // Queue pop
  logic [3:0]            pending_event_count; // Events queued
  logic                  queue_full;      // All entries used
  logic                  overwrite_pop;   // Drop oldest for newest
  logic                  rd_event;        // Read of an event address
  logic                  logged;          // Event entered the queue
  logic                  overrun;         // Event met a full queue
  logic                  key_event_irq_enable;
  logic                  queue_overrun_irq_enable;
  logic                  queue_overrun_overwrite_mode;

  // Event register address test
  function automatic logic is_event_addr(input logic [7:0] a);
    is_event_addr = (a >= keypad_pkg::ADDR_QUEUE_FIRST) &&
                    (a <= keypad_pkg::ADDR_QUEUE_LAST);
  endfunction

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_sync <= 2'b00;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync[1];

  // Row pins through three flops; change taken when last two agree
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      row_s1    <= '1;
      row_s2    <= '1;
      row_s3    <= '1;
      row_level <= '1;
    end
    else
    begin
      row_s1 <= matrix_row_lines;
      row_s2 <= row_s1;
      row_s3 <= row_s2;
      for (int r = 0; r < ROWS; r++)
      begin
        if (row_s2[r] == row_s3[r])
        begin
          row_level[r] <= row_s3[r];
        end
      end
    end
  end

  // Config bits
  assign key_event_irq_enable = int_config[keypad_pkg::CFG_KEY_IRQ_BIT];
  assign queue_overrun_irq_enable = int_config[keypad_pkg::CFG_OVR_IEN_BIT];
  assign queue_overrun_overwrite_mode =
    int_config[keypad_pkg::CFG_OVR_MODE_BIT];

  // Pin setup: non-matrix lines stay pulled-up debounced inputs
  assign row_pullup_en      = '1;
  assign column_pullup_en   = '1;
  assign row_debounce_en    = ~row_en;
  assign column_debounce_en = ~col_en;
  assign matrix_column_lines = '0; // Columns only ever pull low

  // Column drive: all matrix columns low, one at a time while scanning
  always_comb
  begin
    matrix_column_oe = col_en;
    if (state == st_drive)
    begin
      matrix_column_oe = col_en & (COLS'(1) << scan_col);
    end
  end

  // Walked key debounce decisions: two agreeing samples
  assign press_k   = cur[walk_k] && prev[walk_k] && !pressed[walk_k];
  assign release_k = !cur[walk_k] && !prev[walk_k] && pressed[walk_k];

  // Event offered to the queue during the walk
  always_comb
  begin
    ev_valid   = (state == st_walk) && (press_k || release_k);
    ev.pressed = press_k;
    ev.code    = walk_k + 7'h01;
  end

  // Queue control: append, drop or overwrite oldest
  assign queue_full    = (pending_event_count == 4'(DEPTH));
  assign overwrite_pop = ev_valid && queue_full &&
                         queue_overrun_overwrite_mode;
  assign rd_event      = reg_rd && is_event_addr(reg_addr);
  assign fifo_out_ready = (rd_event && fifo_out_valid) ||
                          overwrite_pop;
  assign logged        = ev_valid && fifo_in_ready;
  // A host read in the same cycle frees a slot, so nothing is lost
  assign overrun       = ev_valid && queue_full && !rd_event;
  // Walk stalls only if the queue neither takes nor may drop the event
  assign walk_step     = !ev_valid || fifo_in_ready ||
                         !queue_overrun_overwrite_mode;

  event_fifo #(
    .WIDTH ($bits(keypad_pkg::key_event_type)),
    .DEPTH (DEPTH)
  ) queue (
    .clk       (core_clk),
    .rst_n     (rst_int_n),
    .in_valid  (ev_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (ev),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (head),
    .count     (pending_event_count)
  );

  // Scanner state machine
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      state    <= st_idle;
      timer    <= '0;
      settle   <= '0;
      scan_col <= '0;
      walk_k   <= '0;
      busy     <= 1'b0;
    end
    else
    begin
      // Period timer runs while awake
      if (state == st_idle || timer == '0)
      begin
        timer <= T_RELOAD;
      end
      else
      begin
        timer <= timer - 1'b1;
      end
      case (state)
        st_idle:
        begin
          // Wake on any matrix row low
          if ((row_level & row_en) != row_en)
          begin
            state    <= st_drive;
            scan_col <= '0;
            settle   <= '0;
          end
        end
        st_wait:
        begin
          if (timer == '0)
          begin
            state    <= st_drive;
            scan_col <= '0;
            settle   <= '0;
          end
        end
        st_drive:
        begin
          // Settle plus synchroniser delay before reading rows
          if (settle == S_DONE)
          begin
            settle <= '0;
            if (scan_col == C_LAST)
            begin
              state  <= st_walk;
              walk_k <= '0;
              busy   <= 1'b0;
            end
            else
            begin
              scan_col <= scan_col + 4'h1;
            end
          end
          else
          begin
            settle <= settle + 1'b1;
          end
        end
        st_walk:
        begin
          // Ascending key index, one key per step
          if (walk_step)
          begin
            busy <= busy || cur[walk_k] || prev[walk_k] ||
                    (pressed[walk_k] && !release_k);
            if (walk_k == K_LAST)
            begin
              // Nothing closed or held: back to idle
              if (busy || cur[walk_k] || prev[walk_k] ||
                  (pressed[walk_k] && !release_k))
              begin
                state <= st_wait;
              end
              else
              begin
                state <= st_idle;
              end
            end
            else
            begin
              walk_k <= walk_k + 7'h01;
            end
          end
        end
        default:
        begin
          state <= st_idle;
        end
      endcase
    end
  end

  // Samples and debounced key state
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      cur     <= '0;
      prev    <= '0;
      pressed <= '0;
    end
    else
    begin
      // Capture rows of the driven column, masked to the matrix
      if (state == st_drive && settle == S_DONE)
      begin
        for (int r = 0; r < ROWS; r++)
        begin
          cur[r * COLS + int'(scan_col)] <=
            !row_level[r] && row_en[r] && col_en[scan_col];
        end
      end
      if (state == st_walk && walk_step)
      begin
        if (press_k)
        begin
          pressed[walk_k] <= 1'b1;
        end
        else if (release_k)
        begin
          pressed[walk_k] <= 1'b0;
        end
        prev[walk_k] <= cur[walk_k];
      end
      // Forget previous sample while idle
      if (state == st_idle)
      begin
        prev <= '0;
      end
    end
  end

  // Config and matrix membership writes
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      int_config <= keypad_pkg::CONFIG_RESET;
      row_en     <= keypad_pkg::MATRIX_RESET;
      col_en     <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == keypad_pkg::ADDR_INT_CONFIG)
      begin
        int_config <= reg_wdata;
      end
      else if (reg_addr == keypad_pkg::ADDR_MATRIX_ROWS)
      begin
        row_en <= reg_wdata;
      end
      else if (reg_addr == keypad_pkg::ADDR_MATRIX_COLA)
      begin
        col_en[7:0] <= reg_wdata;
      end
      else if (reg_addr == keypad_pkg::ADDR_MATRIX_COLB)
      begin
        col_en[9:8] <= reg_wdata[1:0];
      end
    end
  end

  // Sticky status flags, set wins over write-one clear
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      key_event_flag     <= 1'b0;
      queue_overrun_flag <= 1'b0;
    end
    else
    begin
      if (logged)
      begin
        key_event_flag <= 1'b1;
      end
      else if (reg_wr && reg_addr == keypad_pkg::ADDR_INT_STATUS &&
               reg_wdata[keypad_pkg::STS_KE_BIT] &&
               pending_event_count == 4'h0)
      begin
        key_event_flag <= 1'b0;
      end
      if (overrun)
      begin
        queue_overrun_flag <= 1'b1;
      end
      else if (reg_wr && reg_addr == keypad_pkg::ADDR_INT_STATUS &&
               reg_wdata[keypad_pkg::STS_OVR_BIT])
      begin
        queue_overrun_flag <= 1'b0;
      end
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      if (reg_addr == keypad_pkg::ADDR_INT_CONFIG)
      begin
        reg_rdata <= int_config;
      end
      else if (reg_addr == keypad_pkg::ADDR_INT_STATUS)
      begin
        reg_rdata <= {6'h00, queue_overrun_flag, key_event_flag};
      end
      else if (reg_addr == keypad_pkg::ADDR_LOCK_COUNT)
      begin
        reg_rdata <= {4'h0, pending_event_count};
      end
      else if (rd_event)
      begin
        reg_rdata <= fifo_out_valid ? head : 8'h00;
      end
      else if (reg_addr == keypad_pkg::ADDR_MATRIX_ROWS)
      begin
        reg_rdata <= row_en;
      end
      else if (reg_addr == keypad_pkg::ADDR_MATRIX_COLA)
      begin
        reg_rdata <= col_en[7:0];
      end
      else if (reg_addr == keypad_pkg::ADDR_MATRIX_COLB)
      begin
        reg_rdata <= {6'h00, col_en[9:8]};
      end
      else
      begin
        reg_rdata <= 8'h00; // Unmapped
      end
    end
  end

  // Open-drain interrupt: pull low while an enabled flag is set
  assign irq_n_out = 1'b0;
  assign irq_n_oe  = (key_event_flag && key_event_irq_enable) ||
                     (queue_overrun_flag && queue_overrun_irq_enable);
endmodule

// ==== verification/keypad_asserts.sv ====
// Port-level checker for the keypad scanner and event queue
`timescale 1ns/1ns
module keypad_asserts (
  input wire logic       core_clk,            // Core clock
  input wire logic       rst_n,               // Reset, active low
  input wire logic [7:0] reg_addr,            // Register address
  input wire logic       reg_wr,              // Write strobe
  input wire logic       reg_rd,              // Read strobe
  input wire logic [7:0] reg_wdata,           // Write data
  input wire logic [7:0] reg_rdata,           // Read data
  input wire logic [9:0] matrix_column_lines, // Column value
  input wire logic [9:0] matrix_column_oe,    // Column drive
  input wire logic [7:0] row_pullup_en,       // Row pull-ups
  input wire logic [9:0] column_pullup_en,    // Column pull-ups
  input wire logic [7:0] row_debounce_en,     // Row debounce
  input wire logic [9:0] column_debounce_en,  // Column debounce
  input wire logic       irq_n_out,           // Interrupt value
  input wire logic       irq_n_oe             // Interrupt drive
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] irq_en; // Shadow of both irq enables
  // Track irq enables from config writes
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_en <= 2'h0;
    else if (reg_wr && reg_addr == 8'h01)
      irq_en <= reg_wdata[1:0];
  end
  AST_COL_LOW: assert property (matrix_column_lines == 10'h000)
    else $error("column value not low");
  AST_PULLUPS: assert property (&row_pullup_en && &column_pullup_en)
    else $error("pull-up turned off");
  AST_IRQ_OD: assert property (irq_n_out == 1'b0)
    else $error("interrupt drives high");
  AST_IRQ_GATE: assert property (irq_n_oe |-> |irq_en)
    else $error("interrupt with both enables off");
  AST_ROW_MEMBER: assert property (reg_wr && reg_addr == 8'h1d |=>
    row_debounce_en == ~$past(reg_wdata))
    else $error("row membership not applied");
  AST_COL_OE: assert property (
    (matrix_column_oe & column_debounce_en) == 10'h000)
    else $error("non-member column driven");
  AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  AST_COUNT_MAX: assert property (reg_rd && reg_addr == 8'h03 |=>
    reg_rdata[3:0] <= 4'ha)
    else $error("event count above ten");
  AST_EVENT_CODE: assert property (reg_rd &&
    reg_addr inside {[8'h04:8'h0d]} |=> reg_rdata == 8'h00 ||
    reg_rdata[6:0] inside {[7'h01:7'h50]})
    else $error("event code out of range");
endmodule

bind keypad_scan_event_fifo keypad_asserts u_chk (
  .core_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .matrix_column_lines, .matrix_column_oe, .row_pullup_en,
  .column_pullup_en, .row_debounce_en, .column_debounce_en,
  .irq_n_out, .irq_n_oe);

// ==== verification/keypad_matrix_model.sv ====
// Switch matrix model: closed keys short rows to driven columns
`timescale 1ns/1ns
module keypad_matrix_model (
  input  wire logic [79:0] closed,    // Key index row*10+col
  input  wire logic [9:0]  column_oe, // Columns pulled low
  output logic      [7:0]  row_level  // Row pin levels
);
  // Rows float high on pull-ups unless a closed key meets a driven column
  always_comb
  begin
    row_level = 8'hff;
    for (int r = 0; r < 8; r++)
      for (int c = 0; c < 10; c++)
        if (closed[r*10+c] && column_oe[c])
          row_level[r] = 1'b0;
  end
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the keypad scanner and event queue
`timescale 1ns/1ns
module tb;
  localparam int SC = 400;          // Shortened sample period
  logic        core_clk  = 1'b0;    // Core clock
  logic        rst_n     = 1'b0;    // Reset, active low
  logic [7:0]  reg_addr  = 8'h00;   // Register address
  logic        reg_wr    = 1'b0;    // Write strobe
  logic        reg_rd    = 1'b0;    // Read strobe
  logic [7:0]  reg_wdata = 8'h00;   // Write data
  logic [7:0]  reg_rdata;           // Read data
  logic [7:0]  rows;                // Row levels
  logic [9:0]  cols, col_oe;        // Column value and drive
  logic [7:0]  row_pu, row_db;      // Row pull-up and debounce
  logic [9:0]  col_pu, col_db;      // Column pull-up and debounce
  logic        irq_out, irq_oe;     // Interrupt value and drive
  logic [79:0] closed    = '0;      // Keys held down
  wire         irq_line  = irq_oe ? irq_out : 1'b1; // Pulled-up line
  int          err_count = 0;       // Mismatches
  int          n_checks  = 0;       // Comparisons
  int          codes [5] = '{1, 12, 23, 34, 45}; // Diagonal keys
  int          ra [7]    = '{1, 2, 3, 29, 30, 31, 32}; // Reset reads

  always #10 core_clk = ~core_clk;

  keypad_scan_event_fifo #(.SAMPLE_CYCLES(SC), .SETTLE_CYCLES(2)) dut (
    .core_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .matrix_row_lines(rows), .matrix_column_lines(cols),
    .matrix_column_oe(col_oe), .row_pullup_en(row_pu),
    .column_pullup_en(col_pu), .row_debounce_en(row_db),
    .column_debounce_en(col_db), .irq_n_out(irq_out), .irq_n_oe(irq_oe));
  keypad_matrix_model km (.closed, .column_oe(col_oe), .row_level(rows));

  // Compare and report
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Register write, strobe held over one edge
  task automatic wr(logic [7:0] a, logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  // Register read, data checked just after the edge that takes the strobe
  task automatic rdc(logic [7:0] a, logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    chk("reg_rdata", e, reg_rdata);
    cyc(1);
  endtask
  // Expected k-th event of a fill, then the extra press
  function automatic logic [7:0] ev(int k);
    if (k < 5)
      return 8'h80 | 8'(codes[k]);
    return (k < 10) ? 8'(codes[k-5]) : 8'hb8;
  endfunction
  // Ten events: five presses in one sample, then five releases
  task automatic fill();
    logic [79:0] m;
    m = '0;
    foreach (codes[i]) m[codes[i]-1] = 1'b1;
    closed = m;
    cyc(3*SC);
    closed = '0;
    cyc(3*SC);
  endtask
  task automatic drain(int s);
    for (int i = 0; i < 10; i++)
      rdc(8'(4 + i), ev(i + s));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog for a hung run
  initial
  begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    $display("mismatch watchdog expected done seen running");
    tally_and_finish();
  end

  initial
  begin
    cyc(2);
    rst_n = 1'b1;
    cyc(3);
    foreach (ra[i]) rdc(8'(ra[i]), 8'h00);
    chk("row_pu", 16'h00ff, row_pu);
    chk("col_pu_db", 16'h03ff, col_pu & col_db);
    chk("row_db", 16'h00ff, row_db);
    chk("col_oe", 16'h0000, col_oe);
    $display("test reset done");
    wr(8'h1d, 8'hff);
    wr(8'h1e, 8'hff);
    wr(8'h1f, 8'h03);
    wr(8'h01, 8'h01);
    chk("debounce", 16'h0000, {row_db, col_db});
    chk("col_oe", 16'h03ff, col_oe);
    rdc(8'h04, 8'h00);
    $display("test config done");
    closed[23] = 1'b1;
    cyc(SC/4);
    closed[23] = 1'b0;
    cyc(3*SC);
    rdc(8'h03, 8'h00);
    closed[23] = 1'b1;
    cyc(3*SC);
    rdc(8'h03, 8'h01);
    rdc(8'h02, 8'h01);
    chk("irq_line", 16'h0000, irq_line);
    wr(8'h02, 8'h01);
    rdc(8'h02, 8'h01);
    closed[23] = 1'b0;
    cyc(SC - 20);
    rdc(8'h03, 8'h01);
    cyc(2*SC);
    rdc(8'h03, 8'h02);
    rdc(8'h0d, 8'h98);
    rdc(8'h04, 8'h18);
    rdc(8'h03, 8'h00);
    rdc(8'h05, 8'h00);
    wr(8'h02, 8'h01);
    rdc(8'h02, 8'h00);
    chk("irq_line", 16'h0001, irq_line);
    $display("test single key done");
    wr(8'h01, 8'h00);
    fill();
    closed[55] = 1'b1;
    cyc(3*SC);
    rdc(8'h03, 8'h0a);
    rdc(8'h02, 8'h03);
    chk("irq_line", 16'h0001, irq_line);
    drain(0);
    rdc(8'h03, 8'h00);
    closed[55] = 1'b0;
    cyc(3*SC);
    rdc(8'h04, 8'h38);
    wr(8'h02, 8'h03);
    rdc(8'h02, 8'h00);
    wr(8'h1f, 8'h00);
    chk("col_oe", 16'h00ff, col_oe);
    closed[79] = 1'b1;
    cyc(3*SC);
    rdc(8'h03, 8'h00);
    closed[79] = 1'b0;
    $display("test discard done");
    wr(8'h01, 8'h22);
    fill();
    chk("irq_line", 16'h0001, irq_line);
    closed[55] = 1'b1;
    cyc(3*SC);
    rdc(8'h03, 8'h0a);
    chk("irq_line", 16'h0000, irq_line);
    drain(1);
    $display("test overwrite done");
    tally_and_finish();
  end
endmodule
